/* File: core/card_slot_clock_reset_config.sv */
// Paged configuration registers of card slots 1 and 2, reached over a two-wire serial bus
// Contract
// - page field selects config, count8, count high, low
// - slot 1 at address 01h, slot 2 02h
// - slot 2 bit 7 alternate detect, resets 0
// - alternate detect set: interrupt at every power-up
// - synchronous mode: reset bit 1 drives reset high
// - reset bit 0 holds card reset low
// - asynchronous mode: reset follows answer-to-reset hardware
// - slot 1 bit 5 drives/reads auxiliary contact A
// - slot 1 bit 4 drives/reads auxiliary contact B
// - asynchronous power-down: bits 3:2 define card clock
// - synchronous power-down active: upper bit stays 0
// - code 00 parks card clock low
// - code 01 parks card clock high
// - code 10 gives half oscillator frequency
// - code 11 uses divider selection bits
// - asynchronous, no power-down: bits 1:0 set frequency
// - synchronous mode: divider bits read 0
// - divider codes give external /1, /2, /4, /5
// - slot 1 bit 7, slot 2 bits 5:4 reserved
// - power-down select picks power-down or divider bits
// - 8-bit count resets to aah, shared by slots
// - 16-bit count resets a4h/74h, shared by slots
`timescale 1ns/100ps
`include "card_cfg_params.svh"
module card_slot_clock_reset_config (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ext_clk1,
  input wire logic ext_clk2,
  input wire logic [1:0] sync_mode,
  input wire logic [1:0] activation_start,
  input wire logic [1:0] powerdown_select,
  input wire logic [1:0] page_sel1,
  input wire logic [1:0] page_sel2,
  input wire logic [1:0] atr_rst_level,
  input wire logic aux_contact_a_in,
  output logic aux_contact_a_out,
  output logic aux_contact_a_oe,
  input wire logic aux_contact_b_in,
  output logic aux_contact_b_out,
  output logic aux_contact_b_oe,
  output logic [1:0] card_rst,
  output logic [1:0] card_clk,
  output logic alt_detect_switch_cfg,
  output logic detect_cfg_irq,
  output logic [7:0] atr_count_8bit,
  output logic [15:0] atr_count_16bit
);
  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [5:0] pin_lvl;
  logic scl_s;
  logic sda_s;
  logic aux_a_s;
  logic aux_b_s;
  logic [1:0] ext_s;
  logic scl_d_r;
  logic sda_d_r;
  logic [1:0] ext_d_r;
  logic [1:0] ext_rise;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  pin_sync #(.W(6)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin({aux_contact_b_in, aux_contact_a_in, ext_clk2, ext_clk1, sda_in, scl_in}),
    .lvl(pin_lvl)
  );

  assign scl_s = pin_lvl[0];
  assign sda_s = pin_lvl[1];
  assign ext_s = pin_lvl[3:2];
  assign aux_a_s = pin_lvl[4];
  assign aux_b_s = pin_lvl[5];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      ext_d_r <= 2'h0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      ext_d_r <= ext_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign ext_rise = ext_s & ~ext_d_r;

  // ******************************************************************
  // Register state
  // ******************************************************************
  logic [7:0] cfg_r [0:1];
  logic [7:0] cnt8_r;
  logic [7:0] cnt_hi_r;
  logic [7:0] cnt_lo_r;
  logic pwrup_r;
  logic [1:0] pg [0:1];
  logic [7:0] view [0:1];

  assign pg[0] = page_sel1;
  assign pg[1] = page_sel2;

  function automatic logic [7:0] slot_mask(input logic idx);
    slot_mask = idx ? `CFG2_MASK : `CFG1_MASK;
  endfunction

  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == `SLOT1_ADDR) || (a == `SLOT2_ADDR);
  endfunction

  // ******************************************************************
  // Serial slave: one register per bus address, every byte of an access goes to that register
  // ******************************************************************
  card_cfg_pkg::i2c_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic rw_r;
  logic slot_r;
  logic sda_oe_r;
  logic wr_pulse_r;
  logic [7:0] wr_byte_r;
  logic [7:0] rd_byte;

  assign rd_byte = view[slot_r];
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= card_cfg_pkg::i2c_idle;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      slot_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_pulse_r <= 1'b0;
      wr_byte_r <= 8'h00;
    end else begin
      wr_pulse_r <= 1'b0;
      if (start_c) begin
        state_r <= card_cfg_pkg::i2c_addr;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_c) begin
        state_r <= card_cfg_pkg::i2c_idle;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          card_cfg_pkg::i2c_addr, card_cfg_pkg::i2c_wdata: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == card_cfg_pkg::i2c_wdata) begin
                wr_pulse_r <= 1'b1;
                wr_byte_r <= sh_r;
                sda_oe_r <= 1'b1;
                state_r <= card_cfg_pkg::i2c_wdata_ack;
              end else if (addr_hit(sh_r[7:1])) begin
                rw_r <= sh_r[0];
                slot_r <= (sh_r[7:1] == `SLOT2_ADDR);
                sda_oe_r <= 1'b1;
                state_r <= card_cfg_pkg::i2c_addr_ack;
              end else begin
                // Another device's address: stay off the bus until next start
                state_r <= card_cfg_pkg::i2c_idle;
              end
            end
          end
          card_cfg_pkg::i2c_addr_ack, card_cfg_pkg::i2c_rdata_ack: begin
            if (state_r == card_cfg_pkg::i2c_rdata_ack && scl_rise && sda_s) begin
              state_r <= card_cfg_pkg::i2c_idle;
            end else if (scl_fall) begin
              if (rw_r) begin
                // Read data is captured here, so a page change mid-byte is harmless
                sh_r <= {rd_byte[6:0], 1'b0};
                sda_oe_r <= ~rd_byte[7];
                bit_cnt_r <= 4'h1;
                state_r <= card_cfg_pkg::i2c_rdata;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= card_cfg_pkg::i2c_wdata;
              end
            end
          end
          card_cfg_pkg::i2c_wdata_ack: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              state_r <= card_cfg_pkg::i2c_wdata;
            end
          end
          card_cfg_pkg::i2c_rdata: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                state_r <= card_cfg_pkg::i2c_rdata_ack;
              end else begin
                sda_oe_r <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          default: state_r <= card_cfg_pkg::i2c_idle;
        endcase
      end
    end
  end

  // ******************************************************************
  // Paged register writes
  // ******************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r[0] <= `CFG1_RESET;
      cfg_r[1] <= `CFG2_RESET;
      cnt8_r <= `CNT8_RESET;
      cnt_hi_r <= `CNT_HI_RESET;
      cnt_lo_r <= `CNT_LO_RESET;
    end else if (wr_pulse_r) begin
      case (pg[slot_r])
        `PAGE_CFG: begin
          // Reserved positions never store, synchronous mode pins divider to 0
          cfg_r[slot_r] <= (wr_byte_r & slot_mask(slot_r)) &
                           {6'h3f, ~sync_mode[slot_r], ~sync_mode[slot_r]};
        end
        `PAGE_CNT8: cnt8_r <= wr_byte_r;
        `PAGE_CNT_HI: cnt_hi_r <= wr_byte_r;
        `PAGE_CNT_LO: cnt_lo_r <= wr_byte_r;
        default: cnt8_r <= cnt8_r;
      endcase
    end
  end

  // ******************************************************************
  // Read view of each slot's paged register
  // ******************************************************************
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (pg[i])
        `PAGE_CFG: begin
          view[i] = cfg_r[i] & slot_mask(1'(i));
          view[i][`BIT_RST_CTL] = sync_mode[i] ? cfg_r[i][`BIT_RST_CTL] : atr_rst_level[i];
          if (i == 0) begin
            view[i][`BIT_AUX_A] = aux_a_s;
            view[i][`BIT_AUX_B] = aux_b_s;
          end
          if (sync_mode[i]) begin
            view[i][1:0] = 2'h0;
            if (powerdown_select[i] && activation_start[i]) begin
              view[i][`BIT_PD_HI] = 1'b0;
            end
          end
        end
        `PAGE_CNT8: view[i] = cnt8_r;
        `PAGE_CNT_HI: view[i] = cnt_hi_r;
        default: view[i] = cnt_lo_r;
      endcase
    end
  end

  // ******************************************************************
  // Card reset lines and auxiliary contacts
  // ******************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      card_rst <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        card_rst[i] <= sync_mode[i] ? cfg_r[i][`BIT_RST_CTL] : atr_rst_level[i];
      end
    end
  end

  // Open-drain contacts: a stored 1 releases the line to its pull-up
  assign aux_contact_a_out = 1'b0;
  assign aux_contact_a_oe = ~cfg_r[0][`BIT_AUX_A];
  assign aux_contact_b_out = 1'b0;
  assign aux_contact_b_oe = ~cfg_r[0][`BIT_AUX_B];

  // ******************************************************************
  // Shared counts and alternate detect option
  // ******************************************************************
  assign atr_count_8bit = cnt8_r;
  assign atr_count_16bit = {cnt_hi_r, cnt_lo_r};
  assign alt_detect_switch_cfg = cfg_r[1][`BIT_ALT_DET];

  // The option falls back to 0 on every power-up, so detection logic built
  // for the other switch type always sees one spurious change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwrup_r <= 1'b1;
      detect_cfg_irq <= 1'b0;
    end else begin
      pwrup_r <= 1'b0;
      detect_cfg_irq <= pwrup_r;
    end
  end

  // ******************************************************************
  // Card clock source selection
  // ******************************************************************
  localparam logic [7:0] OSC_LAST = 8'(`OSC_TICK_CYCLES - 1);
  logic [7:0] osc_cnt_r;
  logic osc_tick;
  card_cfg_pkg::clk_mode_t mode [0:1];
  logic [1:0] div_eff [0:1];
  logic [1:0] pd_eff [0:1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_r <= 8'h00;
    end else begin
      osc_cnt_r <= (osc_cnt_r == OSC_LAST) ? 8'h00 : osc_cnt_r + 8'h01;
    end
  end
  assign osc_tick = (osc_cnt_r == OSC_LAST);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pd_eff[i] = cfg_r[i][3:2];
      if (sync_mode[i] && activation_start[i]) begin
        pd_eff[i][1] = 1'b0;
      end
      div_eff[i] = sync_mode[i] ? 2'h0 : cfg_r[i][1:0];
      if (powerdown_select[i]) begin
        case (pd_eff[i])
          2'h0: mode[i] = card_cfg_pkg::clk_low;
          2'h1: mode[i] = card_cfg_pkg::clk_high;
          2'h2: mode[i] = card_cfg_pkg::clk_osc;
          default: mode[i] = card_cfg_pkg::clk_div;
        endcase
      end else begin
        mode[i] = card_cfg_pkg::clk_div;
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_clk
    card_clk_gen u_gen (
      .clk(clk),
      .nrst(nrst),
      .ext_lvl(ext_s[g]),
      .ext_rise(ext_rise[g]),
      .osc_tick(osc_tick),
      .mode(mode[g]),
      .div_sel(div_eff[g]),
      .card_clk(card_clk[g])
    );
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  sequence s_wbyte_done;
    state_r == card_cfg_pkg::i2c_wdata && scl_fall && bit_cnt_r == 4'h8 && !start_c && !stop_c;
  endsequence

  a_write_strobe: assert property (@(posedge clk) disable iff (!nrst)
    s_wbyte_done |=> wr_pulse_r && sda_oe)
    else $error("written byte not strobed and acknowledged");
  a_cnt8_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_pulse_r && pg[slot_r] == `PAGE_CNT8 |=> cnt8_r == $past(wr_byte_r))
    else $error("count page write lost");
  a_addr_ack: assert property (@(posedge clk) disable iff (!nrst)
    state_r == card_cfg_pkg::i2c_addr_ack |-> sda_oe)
    else $error("own address not acknowledged");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    pg[0] == `PAGE_CFG && pg[1] == `PAGE_CFG |-> !view[0][7] && view[1][5:4] == 2'h0)
    else $error("reserved bit reads non-zero");
  a_sync_rst: assert property (@(posedge clk) disable iff (!nrst)
    sync_mode[0] && !cfg_r[0][`BIT_RST_CTL] ##1 sync_mode[0] |-> !card_rst[0])
    else $error("card reset not low");
  a_async_rst: assert property (@(posedge clk) disable iff (!nrst)
    !sync_mode[1] ##1 1'b1 |-> card_rst[1] == $past(atr_rst_level[1]))
    else $error("card reset not following hardware");
  a_pwrup_pulse: assert property (@(posedge clk) disable iff (!nrst)
    detect_cfg_irq |=> !detect_cfg_irq [*3])
    else $error("power-up event longer than one cycle");
endmodule

/* File: include/card_cfg_params.svh */
// Register map, field positions, reset values and timing counts of the slot configuration block
`ifndef CARD_CFG_PARAMS_SVH
`define CARD_CFG_PARAMS_SVH
`define SLOT1_ADDR 7'h01
`define SLOT2_ADDR 7'h02
`define PAGE_CFG 2'h0
`define PAGE_CNT8 2'h1
`define PAGE_CNT_HI 2'h2
`define PAGE_CNT_LO 2'h3
`define BIT_ALT_DET 7
`define BIT_RST_CTL 6
`define BIT_AUX_A 5
`define BIT_AUX_B 4
`define BIT_PD_HI 3
`define CFG1_MASK 8'h7f
`define CFG2_MASK 8'hcf
`define CFG1_RESET 8'h30
`define CFG2_RESET 8'h00
`define CNT8_RESET 8'haa
`define CNT_HI_RESET 8'ha4
`define CNT_LO_RESET 8'h74
`define CLK_PERIOD_NS 40
`define OSC_PERIOD_NS 120
`define OSC_TICK_CYCLES (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`endif

/* File: include/card_cfg_pkg.sv */
// Types shared by the slot configuration block
package card_cfg_pkg;
  typedef enum logic [2:0] {
    i2c_idle, i2c_addr, i2c_addr_ack, i2c_wdata, i2c_wdata_ack, i2c_rdata, i2c_rdata_ack
  } i2c_state_t;
  typedef enum logic [1:0] {clk_low, clk_high, clk_osc, clk_div} clk_mode_t;
endpackage

/* File: core/pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      lvl <= '0;
    end else begin
      meta_r <= pin;
      lvl <= meta_r;
    end
  end
endmodule

/* File: core/card_clk_gen.sv */
// Card clock generator with glitch-free source switching
`timescale 1ns/100ps
module card_clk_gen (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_lvl,
  input wire logic ext_rise,
  input wire logic osc_tick,
  input wire card_cfg_pkg::clk_mode_t mode,
  input wire logic [1:0] div_sel,
  output logic card_clk
);
  card_cfg_pkg::clk_mode_t act_mode_r;
  logic [1:0] act_div_r;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic take;
  logic clk_d_r;

  function automatic logic [2:0] div_last(input logic [1:0] s);
    case (s)
      2'h1: div_last = 3'h1;
      2'h2: div_last = 3'h3;
      2'h3: div_last = 3'h4;
      default: div_last = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] div_high(input logic [1:0] s);
    case (s)
      2'h1: div_high = 3'h1;
      2'h2: div_high = 3'h2;
      2'h3: div_high = 3'h3;
      default: div_high = 3'h1;
    endcase
  endfunction

  // A new source is taken only after the pin has been low for two cycles, or
  // while it is parked high, and for the oscillator or divider only on that
  // source's own edge, so a low phase that has just begun is never cut into a runt pulse
  always_comb begin
    take = ((mode != act_mode_r) || (div_sel != act_div_r)) &&
           ((!card_clk && !clk_d_r) || act_mode_r == card_cfg_pkg::clk_high) &&
           (mode == card_cfg_pkg::clk_div ? ext_rise :
            mode == card_cfg_pkg::clk_osc ? osc_tick : 1'b1);
    cnt_nxt = (cnt_r >= div_last(act_div_r)) ? 3'h0 : cnt_r + 3'h1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= card_clk;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_mode_r <= card_cfg_pkg::clk_low;
      act_div_r <= 2'h0;
      cnt_r <= 3'h0;
      card_clk <= 1'b0;
    end else if (take) begin
      act_mode_r <= mode;
      act_div_r <= div_sel;
      cnt_r <= 3'h0;
      card_clk <= (mode != card_cfg_pkg::clk_low);
    end else begin
      case (act_mode_r)
        card_cfg_pkg::clk_low: card_clk <= 1'b0;
        card_cfg_pkg::clk_high: card_clk <= 1'b1;
        card_cfg_pkg::clk_osc: if (osc_tick) card_clk <= ~card_clk;
        card_cfg_pkg::clk_div: begin
          if (act_div_r == 2'h0) begin
            card_clk <= ext_lvl;
          end else if (ext_rise) begin
            cnt_r <= cnt_nxt;
            card_clk <= (cnt_nxt < div_high(act_div_r));
          end
        end
        default: card_clk <= 1'b0;
      endcase
    end
  end

  a_low_hold: assert property (@(posedge clk) disable iff (!nrst)
    act_mode_r == card_cfg_pkg::clk_low && !take |=> !card_clk)
    else $error("parked-low clock not low");
  a_osc_toggle: assert property (@(posedge clk) disable iff (!nrst)
    act_mode_r == card_cfg_pkg::clk_osc && osc_tick && !take |=> card_clk != $past(card_clk))
    else $error("oscillator clock did not toggle");
  a_div2_toggle: assert property (@(posedge clk) disable iff (!nrst)
    act_mode_r == card_cfg_pkg::clk_div && act_div_r == 2'h1 && ext_rise && !take
    |=> card_clk != $past(card_clk))
    else $error("divide-by-two clock did not toggle");
  a_no_runt: assert property (@(posedge clk) disable iff (!nrst)
    $fell(card_clk) |=> !card_clk)
    else $error("card clock low phase of one cycle");
endmodule

/* File: test/card_model.sv */
// Card stand-in: contact pull-ups and card clock edge counter
`timescale 1ns/100ps
module card_model (
  input wire logic clk,
  input wire logic [1:0] card_clk,
  input wire logic a_oe,
  input wire logic b_oe,
  input wire logic b_hold_low,
  output logic a_pin,
  output logic b_pin
);
  // ****
  // Contacts
  // ****
  // Pulled up on the card side, so whoever pulls low wins
  assign a_pin = ~a_oe;
  assign b_pin = ~(b_oe | b_hold_low);
  // ****
  // Clock observation
  // ****
  task automatic count_rises(input int slot, input int cycles, output int n);
    logic prev;
    prev = card_clk[slot];
    n = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (card_clk[slot] === 1'b1 && prev === 1'b0) n++;
      prev = card_clk[slot];
    end
  endtask
endmodule

/* File: test/card_slot_clock_reset_config_bench.sv */
// Self-checking bench of the slot configuration block
`timescale 1ns/100ps
`include "card_cfg_params.svh"
module card_slot_clock_reset_config_bench;
  localparam int EXT_HALF = 8;
  localparam int WIN = 320;
  logic clk = 0, nrst = 0, scl_m = 1, sda_m = 1, ext_clk = 0, b_hold_low = 0;
  logic [1:0] sync_mode = 0, activation_start = 0, powerdown_select = 0;
  logic [1:0] page_sel1 = 0, page_sel2 = 0, atr_rst_level = 0;
  logic sda, sda_out, sda_oe, aux_a, aux_b, aux_a_out, aux_a_oe, aux_b_out, aux_b_oe, alt_det, irq;
  logic [1:0] card_rst, card_clk;
  logic [7:0] cnt8;
  logic [15:0] cnt16;
  int err_count = 0, n_checks = 0;
  // ****
  // Clocks, wires and instances
  // ****
  always #(`CLK_PERIOD_NS / 2) clk = ~clk;
  // Offset keeps the external clock off the sampling edges
  initial begin
    #7;
    forever #(EXT_HALF * `CLK_PERIOD_NS) ext_clk = ~ext_clk;
  end
  // Data line is pulled up; the slave only ever pulls it low
  assign sda = sda_m & ~sda_oe;
  card_slot_clock_reset_config DUT (.clk(clk), .nrst(nrst), .scl_in(scl_m), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .ext_clk1(ext_clk), .ext_clk2(ext_clk), .sync_mode(sync_mode),
    .activation_start(activation_start), .powerdown_select(powerdown_select), .page_sel1(page_sel1),
    .page_sel2(page_sel2), .atr_rst_level(atr_rst_level), .aux_contact_a_in(aux_a),
    .aux_contact_a_out(aux_a_out), .aux_contact_a_oe(aux_a_oe), .aux_contact_b_in(aux_b),
    .aux_contact_b_out(aux_b_out), .aux_contact_b_oe(aux_b_oe), .card_rst(card_rst), .card_clk(card_clk),
    .alt_detect_switch_cfg(alt_det), .detect_cfg_irq(irq), .atr_count_8bit(cnt8), .atr_count_16bit(cnt16));
  card_model card (.clk(clk), .card_clk(card_clk), .a_oe(aux_a_oe), .b_oe(aux_b_oe), .b_hold_low(b_hold_low),
    .a_pin(aux_a), .b_pin(aux_b));
  // ****
  // Shared tasks
  // ****
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input int exp, input int got, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    wait_n(1);
    sda_m = b;
    wait_n(5);
    scl_m = 1;
    wait_n(3);
    r = sda;
    wait_n(3);
    scl_m = 0;
  endtask
  // Ninth bit released by the master: slave ack on writes, nack on reads
  task automatic i2c_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
    i2c_bit(1'b1, ack);
  endtask
  task automatic i2c_xfer(input logic [6:0] addr, input logic rd, input logic [7:0] wd, input logic exp_ack,
    output logic [7:0] rdat);
    logic [7:0] junk;
    logic a1, a2;
    sda_m = 1;
    scl_m = 1;
    wait_n(6);
    sda_m = 0;
    wait_n(6);
    scl_m = 0;
    i2c_byte({addr, rd}, junk, a1);
    i2c_byte(rd ? 8'hff : wd, rdat, a2);
    wait_n(1);
    sda_m = 0;
    wait_n(6);
    scl_m = 1;
    wait_n(6);
    sda_m = 1;
    wait_n(6);
    chk_val("address ack", exp_ack, a1);
    if (!rd && !exp_ack) chk_val("data ack", 0, a2);
  endtask
  task automatic reg_wr(input logic [6:0] addr, input logic [7:0] d);
    logic [7:0] junk;
    i2c_xfer(addr, 1'b0, d, 1'b0, junk);
  endtask
  task automatic reg_rd(input logic [6:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] d;
    i2c_xfer(addr, 1'b1, 8'h00, 1'b0, d);
    chk_val(what, exp, d);
  endtask
  task automatic do_reset();
    int hits;
    hits = 0;
    nrst = 0;
    wait_n(3);
    nrst = 1;
    repeat (6) begin
      wait_n(1);
      if (irq === 1'b1) hits++;
    end
    chk_cnt("power-up interrupt pulses", 1, hits, 0);
    chk_val("alternate detect after reset", 0, alt_det);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset_values();
    chk_val("count8 reset", 8'haa, cnt8);
    chk_val("count16 reset", 16'ha474, cnt16);
    chk_val("card reset idle", 0, card_rst);
    reg_rd(7'h01, 8'h30, "slot1 cfg reset");
    reg_rd(7'h02, 8'h00, "slot2 cfg reset");
    $display("test reset_values done");
  endtask
  task automatic t_paging();
    logic [7:0] junk;
    page_sel2 = 2'h1;
    reg_wr(7'h02, 8'h5c);
    chk_val("count8 written via slot2", 8'h5c, cnt8);
    page_sel1 = 2'h1;
    reg_rd(7'h01, 8'h5c, "count8 shared");
    page_sel1 = 2'h2;
    reg_wr(7'h01, 8'h12);
    page_sel1 = 2'h3;
    reg_wr(7'h01, 8'h34);
    chk_val("count16 written", 16'h1234, cnt16);
    page_sel2 = 2'h2;
    reg_rd(7'h02, 8'h12, "count high shared");
    page_sel2 = 2'h3;
    reg_rd(7'h02, 8'h34, "count low shared");
    page_sel1 = 2'h0;
    page_sel2 = 2'h0;
    i2c_xfer(7'h03, 1'b0, 8'h77, 1'b1, junk);
    $display("test paging done");
  endtask
  task automatic t_reserved();
    reg_wr(7'h01, 8'hff);
    reg_rd(7'h01, 8'h3f, "slot1 reserved bit");
    reg_wr(7'h02, 8'hff);
    chk_val("alternate detect set", 1, alt_det);
    reg_rd(7'h02, 8'h8f, "slot2 reserved bits");
    do_reset();
    reg_rd(7'h02, 8'h00, "slot2 cfg after reset");
    $display("test reserved done");
  endtask
  task automatic t_reset_line();
    sync_mode = 2'b11;
    reg_wr(7'h01, 8'h70);
    reg_wr(7'h02, 8'h40);
    wait_n(3);
    chk_val("sync card reset high", 2'b11, card_rst);
    reg_wr(7'h01, 8'h30);
    wait_n(3);
    chk_val("sync card reset low", 2'b10, card_rst);
    sync_mode = 2'b00;
    atr_rst_level = 2'b01;
    wait_n(3);
    chk_val("async card reset", 2'b01, card_rst);
    reg_rd(7'h01, 8'h70, "async reset bit read");
    atr_rst_level = 2'b00;
    reg_wr(7'h02, 8'h00);
    $display("test reset_line done");
  endtask
  task automatic t_aux();
    reg_wr(7'h01, 8'h10);
    chk_val("contact a driven", 1, aux_a_oe);
    chk_val("contact b released", 0, aux_b_oe);
    chk_val("open-drain drive levels", 0, {sda_out, aux_a_out, aux_b_out});
    reg_rd(7'h01, 8'h10, "contact levels");
    b_hold_low = 1;
    reg_rd(7'h01, 8'h00, "contact b held by card");
    b_hold_low = 0;
    reg_wr(7'h01, 8'h20);
    reg_rd(7'h01, 8'h20, "contact b driven");
    reg_wr(7'h01, 8'h30);
    $display("test aux done");
  endtask
  task automatic t_clocks();
    int dv[4] = '{1, 2, 4, 5};
    int n;
    for (int c = 0; c < 4; c++) begin
      reg_wr(7'h01, 8'h30 | 8'(c));
      wait_n(40);
      card.count_rises(0, WIN, n);
      chk_cnt("divided card clock", WIN / (2 * EXT_HALF * dv[c]), n, 1);
    end
    powerdown_select = 2'b01;
    for (int c = 0; c < 4; c++) begin
      reg_wr(7'h01, 8'h31 | 8'(c << 2));
      wait_n(40);
      card.count_rises(0, WIN, n);
      if (c < 2) chk_val("parked card clock", 16'(c), card_clk[0]);
      if (c < 2) chk_cnt("parked clock edges", 0, n, 0);
      if (c == 2) chk_cnt("oscillator clock", WIN / (2 * `OSC_TICK_CYCLES), n, 1);
      if (c == 3) chk_cnt("power-down divider", WIN / (4 * EXT_HALF), n, 1);
    end
    powerdown_select = 2'b00;
    reg_wr(7'h02, 8'h01);
    wait_n(40);
    card.count_rises(1, WIN, n);
    chk_cnt("slot2 divided clock", WIN / (4 * EXT_HALF), n, 1);
    $display("test clocks done");
  endtask
  task automatic t_sync_clock();
    sync_mode = 2'b01;
    activation_start = 2'b01;
    powerdown_select = 2'b01;
    reg_wr(7'h01, 8'h3f);
    wait_n(40);
    chk_val("sync clock level high", 1, card_clk[0]);
    reg_rd(7'h01, 8'h34, "sync cfg read");
    reg_wr(7'h01, 8'h38);
    wait_n(40);
    chk_val("sync clock level low", 0, card_clk[0]);
    sync_mode = 2'b00;
    activation_start = 2'b00;
    powerdown_select = 2'b00;
    $display("test sync_clock done");
  endtask
  // ****
  // Sequence and watchdog
  // ****
  initial begin
    do_reset();
    t_reset_values();
    t_paging();
    t_reserved();
    t_reset_line();
    t_aux();
    t_clocks();
    t_sync_clock();
    end_of_test();
  end
  initial begin
    #(60000 * `CLK_PERIOD_NS);
    err_count++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
